// File: hw/reset_powerdown_status_control.sv
// reset, power-down sequencing, output states and i2c status registers
`timescale 1ns/10ps
module reset_powerdown_status_control
  import rpsc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A,
  parameter logic [7:0] DEVICE_ID = 8'h5A, // value is arbitrary
  parameter int NUM_CH = 8,
  parameter logic [15:0] INIT_CYCLES = 16'(INIT_CYC),
  parameter logic [15:0] STARTUP_CYCLES = 16'(STARTUP_CYC)
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic power_down_n_i,
  input wire logic mute_n_i,
  input wire logic backend_fault_n_i,
  input wire logic osc_trim_i,
  input wire logic vol_nonmute_i,
  input wire logic clip_event_i,
  input wire logic [NUM_CH-1:0] pwm_p_src_i,
  input wire logic [NUM_CH-1:0] pwm_m_src_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic valid_o,
  output logic [NUM_CH-1:0] pwm_p_o,
  output logic [NUM_CH-1:0] pwm_m_o,
  output logic soft_mute_o,
  output logic vol_full_atten_o,
  output logic pwm_startup_o,
  output logic pll_osc_en_o,
  output logic cfg_load_o,
  output logic [31:0] cfg_o
);
  logic hard_n, rst_rel, pdn_rel, mute_n_s, bknd_n_s, scl_s, sda_s;

  // pins act asynchronously on the way in; only their release is synchronised
  assign hard_n = rst_n_i & power_down_n_i;
  pin_sync #(.RESET_VAL(1'b0)) u_rst_rel (.clk_i(sys_clk_i), .arst_n_i(rst_n_i), .d_i(1'b1), .q_o(rst_rel));
  pin_sync #(.RESET_VAL(1'b0)) u_pdn_rel (.clk_i(sys_clk_i), .arst_n_i(hard_n), .d_i(1'b1), .q_o(pdn_rel));
  pin_sync #(.RESET_VAL(1'b1)) u_mute (.clk_i(sys_clk_i), .arst_n_i(hard_n), .d_i(mute_n_i), .q_o(mute_n_s));
  pin_sync #(.RESET_VAL(1'b1)) u_bknd (.clk_i(sys_clk_i), .arst_n_i(hard_n), .d_i(backend_fault_n_i), .q_o(bknd_n_s));
  pin_sync #(.RESET_VAL(1'b1)) u_scl (.clk_i(sys_clk_i), .arst_n_i(hard_n), .d_i(scl_i), .q_o(scl_s));
  pin_sync #(.RESET_VAL(1'b1)) u_sda (.clk_i(sys_clk_i), .arst_n_i(hard_n), .d_i(sda_i), .q_o(sda_s));

  // status byte read back over i2c
  function automatic logic [7:0] rd_byte(input logic [7:0] sub, input logic ok, input logic clip);
    logic [7:0] r;
    r = 8'h00;
    if (sub == GENERAL_STATUS_OFS) begin
      r = DEVICE_ID;
    end else if (sub == ERROR_STATUS_OFS) begin
      r[ERR_NO_ERROR_BIT] = ok;
      r[ERR_CLIP_BIT] = clip;
    end
    return r;
  endfunction : rd_byte

  seq_e st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic trim_reg, trim_next, load_pulse, init_fin, init_done_reg, init_done_next;
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    trim_next = trim_reg;
    load_pulse = 1'b0;
    init_fin = 1'b0;
    case (st_reg)
      ST_HOLD: begin
        cnt_next = 16'h0000;
        if (rst_rel && pdn_rel) begin
          if (init_done_reg) begin
            st_next = ST_STARTUP;
          end else begin
            st_next = ST_INIT;
            load_pulse = 1'b1;
            trim_next = 1'b0;
          end
        end
      end
      ST_INIT: begin
        // counting starts only after the trim command; without it the block stays muted
        if (osc_trim_i) trim_next = 1'b1;
        if (trim_reg) begin
          cnt_next = cnt_reg + 16'h0001;
          if (cnt_reg == INIT_CYCLES - 16'h0001) begin
            st_next = ST_STARTUP;
            cnt_next = 16'h0000;
            init_fin = 1'b1;
          end
        end
      end
      ST_STARTUP: begin
        cnt_next = cnt_reg + 16'h0001;
        if (cnt_reg == STARTUP_CYCLES - 16'h0001) begin
          st_next = ST_OPER;
          cnt_next = 16'h0000;
        end
      end
      ST_OPER: st_next = ST_OPER;
      default: st_next = ST_HOLD;
    endcase
  end
  always_ff @(posedge sys_clk_i or negedge hard_n) begin
    if (!hard_n) begin
      st_reg <= ST_HOLD;
      cnt_reg <= 16'h0000;
      trim_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      trim_reg <= trim_next;
    end
  end

  i2c_e i_st_reg, i_st_next;
  logic [3:0] bitc_reg, bitc_next;
  logic [7:0] shft_reg, shft_next, sub_reg, sub_next, rdata;
  logic rd_reg, rd_next, drv_reg, drv_next, nack_reg, nack_next;
  logic scl_p_reg, sda_p_reg, wr_stb, clip_reg, clip_next;

  assign rdata = rd_byte(sub_reg, valid_o, clip_reg);
  always_comb begin
    i_st_next = i_st_reg;
    bitc_next = bitc_reg;
    shft_next = shft_reg;
    sub_next = sub_reg;
    rd_next = rd_reg;
    drv_next = drv_reg;
    nack_next = nack_reg;
    wr_stb = 1'b0;
    if (scl_s && scl_p_reg && sda_p_reg && !sda_s) begin
      i_st_next = I_ADDR;
      bitc_next = 4'h0;
      drv_next = 1'b0;
    end else if (scl_s && scl_p_reg && !sda_p_reg && sda_s) begin
      i_st_next = I_IDLE;
      drv_next = 1'b0;
    end else if (scl_s && !scl_p_reg) begin
      case (i_st_reg)
        I_ADDR, I_SUB, I_WR: begin
          shft_next = {shft_reg[6:0], sda_s};
          bitc_next = bitc_reg + 4'h1;
        end
        I_RD: bitc_next = bitc_reg + 4'h1;
        I_RACK: nack_next = sda_s;
        default: ;
      endcase
    end else if (!scl_s && scl_p_reg) begin
      case (i_st_reg)
        I_ADDR: begin
          if (bitc_reg == 4'h8) begin
            if (shft_reg[7:1] == DEV_ADDR) begin
              drv_next = 1'b1;
              rd_next = shft_reg[0];
              i_st_next = I_AACK;
            end else begin
              i_st_next = I_IDLE;
            end
          end
        end
        I_AACK: begin
          bitc_next = 4'h0;
          shft_next = rdata;
          drv_next = rd_reg & ~rdata[7];
          i_st_next = rd_reg ? I_RD : I_SUB;
        end
        I_SUB: begin
          if (bitc_reg == 4'h8) begin
            sub_next = shft_reg;
            drv_next = 1'b1;
            i_st_next = I_SACK;
          end
        end
        I_SACK: begin
          bitc_next = 4'h0;
          drv_next = 1'b0;
          i_st_next = I_WR;
        end
        I_WR: begin
          if (bitc_reg == 4'h8) begin
            wr_stb = 1'b1;
            drv_next = 1'b1;
            i_st_next = I_SACK;
          end
        end
        I_RD: begin
          if (bitc_reg == 4'h8) begin
            drv_next = 1'b0;
            i_st_next = I_RACK;
          end else begin
            shft_next = {shft_reg[6:0], 1'b0};
            drv_next = ~shft_reg[6];
          end
        end
        I_RACK: begin
          if (nack_reg) begin
            i_st_next = I_IDLE;
          end else begin
            bitc_next = 4'h0;
            shft_next = rdata;
            drv_next = ~rdata[7];
            i_st_next = I_RD;
          end
        end
        default: i_st_next = I_IDLE;
      endcase
    end
  end

  // the whole slave sits in reset with the pins, so bus traffic is simply not seen
  always_ff @(posedge sys_clk_i or negedge hard_n) begin
    if (!hard_n) begin
      i_st_reg <= I_IDLE;
      bitc_reg <= 4'h0;
      shft_reg <= 8'h00;
      sub_reg <= 8'h00;
      rd_reg <= 1'b0;
      drv_reg <= 1'b0;
      nack_reg <= 1'b0;
      scl_p_reg <= 1'b1;
      sda_p_reg <= 1'b1;
    end else begin
      i_st_reg <= i_st_next;
      bitc_reg <= bitc_next;
      shft_reg <= shft_next;
      sub_reg <= sub_next;
      rd_reg <= rd_next;
      drv_reg <= drv_next;
      nack_reg <= nack_next;
      scl_p_reg <= scl_s;
      sda_p_reg <= sda_s;
    end
  end

  // state kept across power-down, cleared only by the reset pin
  logic [31:0] cfg_reg, cfg_next;
  always_comb begin
    clip_next = clip_reg;
    if (wr_stb && sub_reg == ERROR_STATUS_OFS) clip_next = 1'b0;
    // an event in the clearing cycle wins, so no clip is lost
    if (clip_event_i) clip_next = 1'b1;
    init_done_next = init_done_reg | init_fin;
    cfg_next = load_pulse ? CFG_DEFAULT : cfg_reg;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clip_reg <= 1'b0;
      init_done_reg <= 1'b0;
      cfg_reg <= CFG_DEFAULT;
    end else begin
      clip_reg <= clip_next;
      init_done_reg <= init_done_next;
      cfg_reg <= cfg_next;
    end
  end

  logic [NUM_CH-1:0] pwm_p_reg, pwm_p_next, pwm_m_reg, pwm_m_next;
  logic run, valid_reg, valid_next, smute_reg, smute_next, atten_reg, atten_next;
  logic sup_reg, sup_next, osc_reg, osc_next, load_reg;
  always_comb begin
    run = (st_reg == ST_STARTUP || st_reg == ST_OPER) && bknd_n_s;
    valid_next = (st_reg == ST_OPER) && bknd_n_s;
    pwm_p_next = run ? pwm_p_src_i : '0;
    pwm_m_next = run ? pwm_m_src_i : '0;
    smute_next = (st_reg != ST_OPER) | ~mute_n_s | ~vol_nonmute_i;
    atten_next = (st_reg != ST_OPER) | ~vol_nonmute_i;
    sup_next = (st_reg == ST_STARTUP);
    osc_next = 1'b1;
  end

  // hard_n clears these without a clock edge, so pins go quiet immediately
  always_ff @(posedge sys_clk_i or negedge hard_n) begin
    if (!hard_n) begin
      valid_reg <= 1'b0;
      pwm_p_reg <= '0;
      pwm_m_reg <= '0;
      smute_reg <= 1'b1;
      atten_reg <= 1'b1;
      sup_reg <= 1'b0;
      osc_reg <= 1'b0;
      load_reg <= 1'b0;
    end else begin
      valid_reg <= valid_next;
      pwm_p_reg <= pwm_p_next;
      pwm_m_reg <= pwm_m_next;
      smute_reg <= smute_next;
      atten_reg <= atten_next;
      sup_reg <= sup_next;
      osc_reg <= osc_next;
      load_reg <= load_pulse;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = drv_reg;
  assign valid_o = valid_reg;
  assign pwm_p_o = pwm_p_reg;
  assign pwm_m_o = pwm_m_reg;
  assign soft_mute_o = smute_reg;
  assign vol_full_atten_o = atten_reg;
  assign pwm_startup_o = sup_reg;
  assign pll_osc_en_o = osc_reg;
  assign cfg_load_o = load_reg;
  assign cfg_o = cfg_reg;

  property p_rst_quiet;
    @(posedge sys_clk_i) !rst_n_i |-> !valid_o && pwm_p_o == '0 && pwm_m_o == '0 && !sda_oe_o;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");

  property p_pdn_quiet;
    @(posedge sys_clk_i) !power_down_n_i |-> !valid_o && pwm_p_o == '0 && !pll_osc_en_o && !sda_oe_o;
  endproperty
  a_pdn_quiet: assert property (p_pdn_quiet) else $error("outputs active in power-down");

  property p_atten;
    @(posedge sys_clk_i) !hard_n |-> vol_full_atten_o;
  endproperty
  a_atten: assert property (p_atten) else $error("volume not attenuated");

  property p_no_err_bit;
    @(posedge sys_clk_i) disable iff (!hard_n) sub_reg == ERROR_STATUS_OFS |-> rdata[ERR_NO_ERROR_BIT] == valid_o;
  endproperty
  a_no_err_bit: assert property (p_no_err_bit) else $error("no-error bit differs from valid");

  property p_clip_set;
    @(posedge sys_clk_i) disable iff (!rst_n_i) clip_event_i |=> clip_reg;
  endproperty
  a_clip_set: assert property (p_clip_set) else $error("clip flag lost");

  property p_clip_clr;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      wr_stb && sub_reg == ERROR_STATUS_OFS && !clip_event_i |=> !clip_reg;
  endproperty
  a_clip_clr: assert property (p_clip_clr) else $error("clip flag not cleared");

  property p_quiet_start;
    @(posedge sys_clk_i) disable iff (!hard_n) $changed(st_reg) && st_reg == ST_OPER |-> $past(st_reg) == ST_STARTUP;
  endproperty
  a_quiet_start: assert property (p_quiet_start) else $error("operation without start-up");

  property p_vol_mute;
    @(posedge sys_clk_i) disable iff (!hard_n) !vol_nonmute_i |=> soft_mute_o && vol_full_atten_o;
  endproperty
  a_vol_mute: assert property (p_vol_mute) else $error("unmuted without volume");

  property p_defaults;
    @(posedge sys_clk_i) disable iff (!hard_n) cfg_load_o |-> cfg_o == CFG_DEFAULT && $past(st_reg) == ST_HOLD;
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not loaded");

  property p_sync_rel;
    @(posedge sys_clk_i) $rose(hard_n) |-> st_reg == ST_HOLD [*2];
  endproperty
  a_sync_rel: assert property (p_sync_rel) else $error("release not synchronised");

  c_init: cover property (@(posedge sys_clk_i) cfg_load_o ##[1:1000] st_reg == ST_STARTUP);
  c_oper: cover property (@(posedge sys_clk_i) $rose(valid_o));
  c_clip: cover property (@(posedge sys_clk_i) clip_reg ##1 !clip_reg);
  c_rd: cover property (@(posedge sys_clk_i) i_st_reg == I_RACK);
endmodule : reset_powerdown_status_control

// File: hw/rpsc_pkg.sv
// constants and types for the reset, power-down and status control block
// Summary of operation
// - status registers at 0x01 and 0x02
// - no-error bit equals valid output
// - sticky clip flag, a write to 0x02 clears
// - async reset forces hard mute, no switching
// - reset sets full attenuation at once
// - reset held: ignore i2c and audio
// - reset: valid low, pwm low, sda released
// - leave hard mute via quiet start-up
// - reset release loads default settings
// - defaults: hpf, automute, unmuted channels
// - defaults: manual bank, bypasses, mixer remap off
// - operate muted until non-mute volume written
// - power-down stops pll and oscillator
// - power-down: full attenuation, no ramp
// - power-down held: ignore i2c and audio
// - power-down: valid low, pwm low
// - power-down stops pwm at once
// - power-down release goes to pin-set state
package rpsc_pkg;
  localparam logic [7:0] GENERAL_STATUS_OFS = 8'h01;
  localparam logic [7:0] ERROR_STATUS_OFS = 8'h02;
  localparam int ERR_NO_ERROR_BIT = 0;
  localparam int ERR_CLIP_BIT = 1;
  localparam int CLK_PERIOD_NS = 25;
  localparam int INIT_TIME_NS = 100000;
  localparam int STARTUP_TIME_NS = 50000;
  localparam int INIT_CYC = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CYC = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CFG_EIGHT_CH_BIT = 0;
  localparam int CFG_HPF_BIT = 1;
  localparam int CFG_IN_AMUTE_BIT = 2;
  localparam int CFG_OUT_AMUTE_BIT = 3;
  localparam int CFG_MANUAL_BANK_BIT = 4;
  localparam int CFG_HARD_UNMUTE_BIT = 5;
  localparam int CFG_TONE_BYP_BIT = 6;
  localparam int CFG_DRC_BYP_BIT = 7;
  localparam int CFG_AM_EN_BIT = 8;
  localparam int CFG_MIX_REMAP_BIT = 9;
  localparam int CFG_CH_UNMUTED_BIT = 10;
  localparam int CFG_FILTSET_LSB = 12;
  localparam logic [1:0] FILTSET_DEFAULT = 2'h3;
  localparam int CFG_FMT_LSB = 14;
  localparam logic [1:0] FMT_I2S_24 = 2'h0;
  localparam logic [7:0] MIXER_CTRL_REG = 8'hD0;
  localparam int MIXER_REMAP_CTRL_BIT = 30;
  localparam int MOD_LIMIT_PERMILLE = 937;
  localparam int AUTOMUTE_DELAY_US = 14900;
  localparam int VOL_RAMP_US = 42600;
  localparam int AM_IF_KHZ = 455;
  localparam int CH_VOL_DB = 0;
  localparam logic [31:0] CFG_DEFAULT = (32'h1 << CFG_EIGHT_CH_BIT) | (32'h1 << CFG_HPF_BIT)
    | (32'h1 << CFG_IN_AMUTE_BIT) | (32'h1 << CFG_OUT_AMUTE_BIT) | (32'h1 << CFG_MANUAL_BANK_BIT)
    | (32'h1 << CFG_HARD_UNMUTE_BIT) | (32'h1 << CFG_TONE_BYP_BIT) | (32'h1 << CFG_DRC_BYP_BIT)
    | (32'h1 << CFG_CH_UNMUTED_BIT) | (32'(FILTSET_DEFAULT) << CFG_FILTSET_LSB)
    | (32'(FMT_I2S_24) << CFG_FMT_LSB);
  typedef enum logic [1:0] {ST_HOLD, ST_INIT, ST_STARTUP, ST_OPER} seq_e;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_AACK, I_SUB, I_SACK, I_WR, I_RD, I_RACK} i2c_e;
endpackage : rpsc_pkg

// File: hw/pin_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  logic q_reg;
  logic q_next;

  // stage 0 only feeds stage 1; the output moves once stages 1 and 2 agree
  always_comb begin
    sh_next = {sh_reg[1:0], d_i};
    q_next = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : q_reg;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sh_reg <= {3{RESET_VAL}};
      q_reg <= RESET_VAL;
    end else begin
      sh_reg <= sh_next;
      q_reg <= q_next;
    end
  end

  assign q_o = q_reg;
endmodule : pin_sync

// File: tb/i2c_host_model.sv
// host controller model: i2c master toward the status registers
`timescale 1ns/10ps
module i2c_host_model #(
  parameter logic [6:0] ADDR = 7'h2A,
  parameter int HALF = 12
) (
  input wire logic sys_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  // phases well above the input sync delay, so sda settles before scl rises
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic hp();
    repeat (HALF) @(posedge sys_clk_i);
  endtask : hp
  task automatic start();
    sda_low_o <= 1'b1;
    hp();
    scl_o <= 1'b0;
  endtask : start
  task automatic stop();
    repeat (3) @(posedge sys_clk_i);
    sda_low_o <= 1'b1;
    hp();
    scl_o <= 1'b1;
    hp();
    sda_low_o <= 1'b0;
    hp();
  endtask : stop
  // data moves a few clocks after scl falls, never on the same edge
  task automatic bit_io(input logic b, output logic r);
    repeat (3) @(posedge sys_clk_i);
    sda_low_o <= ~b;
    hp();
    scl_o <= 1'b1;
    hp();
    r = sda_i;
    scl_o <= 1'b0;
  endtask : bit_io
  // ninth bit always released: ack seen on writes, nack sent on reads
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic n;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(1'b1, n);
    ack = ~n;
  endtask : xbyte
  task automatic wr_reg(input logic [7:0] s, input logic [7:0] d, output logic ack);
    logic [7:0] q;
    logic a0, a1, a2;
    start();
    xbyte({ADDR, 1'b0}, q, a0);
    xbyte(s, q, a1);
    xbyte(d, q, a2);
    stop();
    ack = a0 & a1 & a2;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] s, output logic [7:0] d, output logic ack);
    logic [7:0] q;
    logic a0, a1, a2, n;
    start();
    xbyte({ADDR, 1'b0}, q, a0);
    xbyte(s, q, a1);
    stop();
    start();
    xbyte({ADDR, 1'b1}, q, a2);
    xbyte(8'hFF, d, n);
    stop();
    ack = a0 & a1 & a2;
  endtask : rd_reg
endmodule : i2c_host_model

// File: tb/reset_powerdown_status_control_tb_top.sv
// self-checking bench for reset, power-down and status control
`timescale 1ns/10ps
module reset_powerdown_status_control_tb_top;
  import rpsc_pkg::*;
  localparam logic [7:0] ID = 8'h5A; // value is arbitrary
  localparam logic [7:0] OK = 8'h1 << ERR_NO_ERROR_BIT;
  localparam logic [7:0] CLIP = 8'h1 << ERR_CLIP_BIT;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b1;
  logic pdn_n = 1'b1;
  logic mute_n = 1'b0;
  logic fault_n = 1'b1;
  logic trim = 1'b0;
  logic vol_nm = 1'b0;
  logic clip_ev = 1'b0;
  logic [7:0] src_p = 8'hA5;
  logic [7:0] src_m = 8'h3C;
  logic scl, sda_low, sda_oe, sda_out, valid, soft_mute, atten, startup, osc_en, cfg_load;
  logic [7:0] pwm_p, pwm_m;
  logic [31:0] cfg;
  wire sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;
  int error_cnt = 0;
  int checks = 0;
  always #12.5 sys_clk_i = ~sys_clk_i;
  reset_powerdown_status_control #(.INIT_CYCLES(16'h0008), .STARTUP_CYCLES(16'h0008)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .power_down_n_i(pdn_n), .mute_n_i(mute_n),
    .backend_fault_n_i(fault_n), .osc_trim_i(trim), .vol_nonmute_i(vol_nm), .clip_event_i(clip_ev),
    .pwm_p_src_i(src_p), .pwm_m_src_i(src_m), .scl_i(scl), .sda_i(sda), .sda_o(sda_out), .sda_oe_o(sda_oe),
    .valid_o(valid), .pwm_p_o(pwm_p), .pwm_m_o(pwm_m), .soft_mute_o(soft_mute),
    .vol_full_atten_o(atten), .pwm_startup_o(startup), .pll_osc_en_o(osc_en),
    .cfg_load_o(cfg_load), .cfg_o(cfg));
  i2c_host_model host_u (.sys_clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  task automatic stop_test();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk1(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t flag got %b exp %b", $time, g, e);
    end
  endtask : chk1
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t byte got %h exp %h", $time, g, e);
    end
  endtask : chk8
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t word got %h exp %h", $time, g, e);
    end
  endtask : chk32
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      error_cnt++;
      $display("[ERR] %0t wait limit reached", $time);
      stop_test();
    end
  endtask : tmo
  task automatic nc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask : nc
  task automatic rd(input logic [7:0] s, input logic [7:0] e);
    logic [7:0] d;
    logic a;
    host_u.rd_reg(s, d, a);
    chk1(a, 1'b1);
    chk8(d, e);
  endtask : rd
  // outputs forced quiet with no edge needed; one check set for both pins
  task automatic quiet();
    chk1(valid, 1'b0);
    chk8(pwm_p | pwm_m, 8'h00);
    chk1(atten, 1'b1);
    chk1(osc_en, 1'b0);
    chk1(sda_oe, 1'b0);
  endtask : quiet
  task automatic t_bringup();
    int n;
    nc(1);
    quiet();
    chk32(cfg, CFG_DEFAULT);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    for (n = 0; n < 20 && cfg_load !== 1'b1; n++) nc(1);
    tmo(n, 20);
    chk1(n >= 3 && n <= 6, 1'b1);
    chk32(cfg, CFG_DEFAULT);
    nc(40);
    chk1(startup | valid, 1'b0);
    chk1(soft_mute & atten, 1'b1);
    @(posedge sys_clk_i);
    trim <= 1'b1;
    @(posedge sys_clk_i);
    trim <= 1'b0;
    for (n = 0; n < 40 && startup !== 1'b1; n++) nc(1);
    tmo(n, 40);
    nc(2);
    chk8(pwm_p, src_p);
    chk8(pwm_m, src_m);
    for (n = 0; n < 40 && valid !== 1'b1; n++) nc(1);
    tmo(n, 40);
    chk1(soft_mute & atten & osc_en, 1'b1);
    @(posedge sys_clk_i);
    mute_n <= 1'b1;
    vol_nm <= 1'b1;
    nc(8);
    chk1(soft_mute | atten, 1'b0);
  endtask : t_bringup
  task automatic t_status();
    logic a;
    rd(GENERAL_STATUS_OFS, ID);
    rd(ERROR_STATUS_OFS, OK);
    @(posedge sys_clk_i);
    clip_ev <= 1'b1;
    @(posedge sys_clk_i);
    clip_ev <= 1'b0;
    rd(ERROR_STATUS_OFS, OK | CLIP);
    rd(ERROR_STATUS_OFS, OK | CLIP);
    host_u.wr_reg(ERROR_STATUS_OFS, 8'h00, a);
    chk1(a, 1'b1);
    rd(ERROR_STATUS_OFS, OK);
    rd(8'h05, 8'h00);
  endtask : t_status
  task automatic t_fault();
    @(posedge sys_clk_i);
    fault_n <= 1'b0;
    nc(8);
    chk1(valid, 1'b0);
    chk8(pwm_p, 8'h00);
    rd(ERROR_STATUS_OFS, 8'h00);
    @(posedge sys_clk_i);
    fault_n <= 1'b1;
  endtask : t_fault
  task automatic t_pdn();
    logic [7:0] d;
    logic a;
    logic seen;
    int n;
    @(posedge sys_clk_i);
    mute_n <= 1'b0;
    nc(8);
    @(posedge sys_clk_i);
    pdn_n <= 1'b0;
    #1;
    quiet();
    host_u.rd_reg(GENERAL_STATUS_OFS, d, a);
    chk1(a, 1'b0);
    chk8(pwm_p | pwm_m, 8'h00);
    nc(8);
    @(posedge sys_clk_i);
    pdn_n <= 1'b1;
    mute_n <= 1'b1;
    seen = 1'b0;
    for (n = 0; n < 60 && valid !== 1'b1; n++) begin
      nc(1);
      seen = seen | (cfg_load === 1'b1);
    end
    tmo(n, 60);
    chk1(seen, 1'b0);
    chk1(soft_mute | atten, 1'b0);
  endtask : t_pdn
  task automatic t_rst_mid();
    logic [7:0] d;
    logic a;
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    #1;
    quiet();
    chk32(cfg, CFG_DEFAULT);
    host_u.rd_reg(ERROR_STATUS_OFS, d, a);
    chk1(a, 1'b0);
    chk1(sda_oe | valid, 1'b0);
  endtask : t_rst_mid
  initial begin
    // driven low after time 0 so the asynchronous resets see a falling edge
    rst_n_i <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    t_bringup();
    t_status();
    t_fault();
    t_pdn();
    t_rst_mid();
    stop_test();
  end
endmodule : reset_powerdown_status_control_tb_top
